/* src/uart_pkg.sv */
// Shared constants, register map and carrier types for the serial port control block.
package uart_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [9:0] IDX_POWER  = 10'h087;
    localparam logic [9:0] IDX_SERIAL = 10'h098;
    localparam logic [9:0] IDX_DATA   = 10'h099;
    localparam logic [9:0] IDX_RELOAD = 10'h09A;
    localparam logic [9:0] IDX_BAUD   = 10'h09B;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         SC_TOP_BIT    = 7;
    localparam int         SC_NEXT_BIT   = 6;
    localparam int         PC_EFS_BIT    = 6;
    localparam int         DATA_VALID_BIT = 8;
    localparam logic [4:0] BAUD_RST      = 5'h00;
    localparam logic [5:0] SC_LOW_RST    = 6'h00;
    localparam logic [7:0] RELOAD_RST    = 8'h00;

    // ************************************************************
    // Cycle counts and sizes
    // ************************************************************
    localparam logic [3:0] FIXED_DIV     = 4'hC;
    localparam logic [3:0] FAST_PRESCALE = 4'h2;
    localparam logic [3:0] SLOW_PRESCALE = 4'hC;
    localparam int         DATA_W        = 8;
    localparam int         FIFO_DEPTH    = 8;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic generator_run;
        logic tx_clock_select;
        logic rx_clock_select;
        logic fast_range_select;
        logic mode0_clock_source;
    } baud_ctrl_s;

    typedef struct packed {
        logic              stop_ok;
        logic [DATA_W-1:0] data;
    } rx_char_s;

    typedef enum logic [1:0] {
        MODE_SHIFT  = 2'b00,
        MODE_UART8  = 2'b01,
        MODE_UART9  = 2'b10,
        MODE_UART9V = 2'b11
    } serial_mode_e;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b01,
        APB_ACCESS = 2'b10
    } apb_state_e;

endpackage : uart_pkg

/* src/sync_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    nxt_cnt;
    logic             not_full_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid && not_full_ff;
    assign out_valid = (cnt_ff != '0);
    assign pop       = out_ready && out_valid;
    assign out_data  = mem[rd_ff];
    assign in_ready  = not_full_ff;

    // Occupancy after this cycle's push and pop.
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (push && !pop)
            nxt_cnt = cnt_ff + CW'(1);
        else if (pop && !push)
            nxt_cnt = cnt_ff - CW'(1);
    end

    // Ready is registered so the source sees a clean level.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff      <= '0;
            not_full_ff <= 1'b1;
        end
        else
        begin
            cnt_ff      <= nxt_cnt;
            not_full_ff <= (nxt_cnt != CW'(DEPTH));
        end
    end

    // Pointers wrap at the depth.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
        end
    end

    // Storage carries no reset; while empty, out_data still shows the stale entry at the read pointer.
    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wr_ff] <= in_data;
    end

endmodule : sync_fifo

/* src/baud_gen.sv */
// Internal baud rate generator with slow and fast prescale ranges.
`timescale 1ns/1ns
module baud_gen (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic       fast,
    input  wire logic [7:0] reload,
    // Pulses
    output logic            ovf,
    output logic            baud
);
    import uart_pkg::*;

    logic [3:0] pre_ff;
    logic [7:0] cnt_ff;
    logic       half_ff;
    logic [3:0] limit;
    logic       tick;

    assign limit = fast ? FAST_PRESCALE : SLOW_PRESCALE;
    // A range switch mid-count must not let the prescaler run past its end.
    assign tick  = run && (pre_ff >= limit - 4'h1);
    assign ovf   = tick && (cnt_ff == 8'hFF);
    assign baud  = ovf && half_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_ff <= 4'h0;
        else if (!run || tick)
            pre_ff <= 4'h0;
        else
            pre_ff <= pre_ff + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff  <= 8'h00;
            half_ff <= 1'b0;
        end
        else if (!run)
        begin
            cnt_ff  <= reload;
            half_ff <= 1'b0;
        end
        else if (ovf)
        begin
            cnt_ff  <= reload;
            half_ff <= !half_ff;
        end
        else if (tick)
            cnt_ff <= cnt_ff + 8'h01;
    end

    fast_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        run && fast && tick ##1 (run && fast) [*2] |-> tick) else $error("fast prescale spacing wrong");
    fast_baud_a: assert property (@(posedge pclk) disable iff (!presetn)
        baud && run && fast && reload == 8'hFF ##1 (run && fast && reload == 8'hFF) [*4] |-> baud)
        else $error("fast baud period wrong");

endmodule : baud_gen

/* src/uart_baud_and_serial_control.sv */
// Baud and serial control registers with clock source selection and receive FIFO.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
module uart_baud_and_serial_control (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Timer 1 overflow pulse
    input  wire logic                  timer1_ovf,
    // Received characters
    input  wire logic                  rx_valid,
    input  wire uart_pkg::rx_char_s    rx_char,
    output logic                       rx_ready,
    // Serial clocking and mode
    output logic                       tx_clk_en,
    output logic                       rx_clk_en,
    output uart_pkg::serial_mode_e     serial_mode
);
    import uart_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    baud_ctrl_s        baud_ff;
    logic [7:0]        reload_ff;
    logic              efs_ff;
    logic              mode_bit_0_ff;
    logic              mode_bit_1_ff;
    logic              framing_error_flag_ff;
    logic              overrun_flag_ff;
    logic [5:0]        sc_low_ff;
    apb_state_e        state_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic              tx_clk_en_ff;
    logic              rx_clk_en_ff;
    serial_mode_e      serial_mode_ff;
    logic [3:0]        div_ff;

    logic [9:0]        idx;
    logic              setup;
    logic              acc_done;
    logic              wr_done;
    logic              rd_done;
    logic              mapped;
    logic [31:0]       rd_word;
    logic              sc_bit7;
    logic              sc_bit6;
    logic              fe_set;
    logic              ovr_set;
    logic              wr_serial;
    logic              fifo_pop;
    logic              fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic              brg_ovf;
    logic              brg_baud;
    logic              div_tick;
    logic              m0_clk;
    logic              shift_mode;
    logic [1:0]        src_sel;
    logic [1:0]        uart_clk;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign idx      = paddr[11:2];
    assign setup    = psel && !penable;
    assign acc_done = psel && penable && pready_ff;
    assign wr_done  = acc_done && pwrite;
    assign rd_done  = acc_done && !pwrite;
    assign mapped   = (paddr[1:0] == 2'b00) &&
                      (idx == IDX_POWER || idx == IDX_SERIAL || idx == IDX_DATA ||
                       idx == IDX_RELOAD || idx == IDX_BAUD);
    assign wr_serial = wr_done && mapped && (idx == IDX_SERIAL);
    assign sc_bit7 = efs_ff ? framing_error_flag_ff : mode_bit_0_ff;
    assign sc_bit6 = efs_ff ? overrun_flag_ff : mode_bit_1_ff;
    // Read data mux, captured at the setup cycle.
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (idx)
            IDX_SERIAL: rd_word = {24'h00_0000, sc_bit7, sc_bit6, sc_low_ff};
            IDX_DATA:   rd_word = {23'h00_0000, fifo_valid, fifo_data};
            IDX_RELOAD: rd_word = {24'h00_0000, reload_ff};
            IDX_BAUD:   rd_word = {24'h00_0000, 3'b000, baud_ff};
            IDX_POWER:  rd_word = {24'h00_0000, 1'b0, efs_ff, 6'h00};
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase per transfer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff  <= APB_IDLE;
            pready_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                APB_IDLE:
                begin
                    pready_ff <= setup;
                    if (setup)
                        state_ff <= APB_ACCESS;
                end
                // The access cycle, and any stray code, returns to idle.
                default:
                begin
                    pready_ff <= 1'b0;
                    state_ff  <= APB_IDLE;
                end
            endcase
        end
    end
    // Read data and error answer are loaded at setup and held through access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup && state_ff == APB_IDLE)
        begin
            prdata_ff  <= mapped ? rd_word : 32'h0000_0000;
            pslverr_ff <= !mapped;
        end
        else if (!acc_done)
            pslverr_ff <= 1'b0;
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    // defined bits reset clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_ff   <= baud_ctrl_s'(BAUD_RST);
            reload_ff <= RELOAD_RST;
            efs_ff    <= 1'b0;
        end
        else if (wr_done && mapped)
        begin
            if (idx == IDX_BAUD)
                baud_ff <= baud_ctrl_s'(pwdata[4:0]);
            if (idx == IDX_RELOAD)
                reload_ff <= pwdata[7:0];
            if (idx == IDX_POWER)
                efs_ff <= pwdata[PC_EFS_BIT];
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_bit_0_ff <= 1'b0;
            mode_bit_1_ff <= 1'b0;
            sc_low_ff     <= SC_LOW_RST;
        end
        else if (wr_serial)
        begin
            sc_low_ff <= pwdata[5:0];
            if (!efs_ff)
            begin
                mode_bit_0_ff <= pwdata[SC_TOP_BIT];
                mode_bit_1_ff <= pwdata[SC_NEXT_BIT];
            end
        end
    end
    assign fe_set  = rx_valid && !rx_char.stop_ok;
    assign ovr_set = rx_valid && !rx_ready && efs_ff;
    // Writing zero through the error view clears a flag; a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            framing_error_flag_ff <= 1'b0;
            overrun_flag_ff       <= 1'b0;
        end
        else
        begin
            if (fe_set)
                framing_error_flag_ff <= 1'b1;
            else if (wr_serial && efs_ff && !pwdata[SC_TOP_BIT])
                framing_error_flag_ff <= 1'b0;
            if (ovr_set)
                overrun_flag_ff <= 1'b1;
            else if (wr_serial && efs_ff && !pwdata[SC_NEXT_BIT])
                overrun_flag_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Receive buffer
    // ************************************************************
    // Pop only when the read already returned a valid character, so none is lost.
    assign fifo_pop = rd_done && mapped && (idx == IDX_DATA) && prdata_ff[DATA_VALID_BIT];
    sync_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_char.data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ************************************************************
    // Clock sources
    // ************************************************************
    baud_gen u_baud_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (baud_ff.generator_run),
        .fast    (baud_ff.fast_range_select),
        .reload  (reload_ff),
        .ovf     (brg_ovf),
        .baud    (brg_baud)
    );
    // Fixed divide by twelve for the compatible shift clock.
    assign div_tick = (div_ff == FIXED_DIV - 4'h1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_ff <= 4'h0;
        else
            div_ff <= div_tick ? 4'h0 : div_ff + 4'h1;
    end
    assign m0_clk = baud_ff.mode0_clock_source ? brg_baud : div_tick;
    assign src_sel = {baud_ff.rx_clock_select, baud_ff.tx_clock_select};
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_clk_sel
        assign uart_clk[ch] = src_sel[ch] ? brg_ovf : timer1_ovf;
    end
    assign shift_mode = ({mode_bit_0_ff, mode_bit_1_ff} == MODE_SHIFT);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_clk_en_ff   <= 1'b0;
            rx_clk_en_ff   <= 1'b0;
            serial_mode_ff <= MODE_SHIFT;
        end
        else
        begin
            tx_clk_en_ff   <= shift_mode ? m0_clk : uart_clk[0];
            rx_clk_en_ff   <= shift_mode ? m0_clk : uart_clk[1];
            serial_mode_ff <= serial_mode_e'({mode_bit_0_ff, mode_bit_1_ff});
        end
    end

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign tx_clk_en   = tx_clk_en_ff;
    assign rx_clk_en   = rx_clk_en_ff;
    assign serial_mode = serial_mode_ff;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    gen_stopped_a: assert property (!baud_ff.generator_run [*2] |-> !brg_ovf)
        else $error("generator pulsed while stopped");
    tx_source_a: assert property (!shift_mode && !baud_ff.tx_clock_select && timer1_ovf |=> tx_clk_en_ff)
        else $error("transmit clock missed timer pulse");
    rx_source_a: assert property (!shift_mode && baud_ff.rx_clock_select && brg_ovf |=> rx_clk_en_ff)
        else $error("receive clock missed generator pulse");
    fixed_div_a: assert property (div_tick |=> (!div_tick) [*8] ##4 div_tick)
        else $error("fixed divider spacing wrong");
    baud_read_a: assert property (pready_ff && idx == IDX_BAUD && !pwrite |-> prdata_ff[7:5] == 3'b000)
        else $error("reserved bits read nonzero");
    baud_reset_a: assert property (!$past(presetn) |-> baud_ff == baud_ctrl_s'(BAUD_RST))
        else $error("baud control not clear after reset");
    top_view_a: assert property (setup && state_ff == APB_IDLE && idx == IDX_SERIAL |=>
        prdata_ff[SC_TOP_BIT] == ($past(efs_ff) ? $past(framing_error_flag_ff) : $past(mode_bit_0_ff)))
        else $error("bit 7 view wrong");
    fe_sticky_a: assert property (fe_set |=> framing_error_flag_ff)
        else $error("framing error not set");
    mode_hold_a: assert property (efs_ff && wr_serial |=> $stable(mode_bit_0_ff) && $stable(mode_bit_1_ff))
        else $error("mode bits written under error view");
    shift_clk_a: assert property (shift_mode |=> tx_clk_en_ff == $past(m0_clk) && rx_clk_en_ff == $past(m0_clk))
        else $error("shift mode clock wrong");
    sc_reset_a: assert property (!$past(presetn) |-> !mode_bit_0_ff && !framing_error_flag_ff && sc_low_ff == SC_LOW_RST)
        else $error("serial control not clear after reset");
    ovr_sticky_a: assert property (ovr_set |=> overrun_flag_ff)
        else $error("overrun not set");
    fe_seen_c:    cover property (fe_set ##1 wr_serial && efs_ff);
    ovr_seen_c:   cover property (ovr_set);
    brg_shift_c:  cover property (shift_mode && baud_ff.mode0_clock_source && brg_baud);
    fifo_drain_c: cover property (fifo_pop && !rx_ready);

endmodule : uart_baud_and_serial_control

/* bench/rx_partner.sv */
// Far-side model: serial receiver handing over characters, plus a timer 1 overflow source.
`timescale 1ns/1ns
module rx_partner (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Character handover
    input  wire logic           rx_ready,
    output logic                rx_valid,
    output uart_pkg::rx_char_s  rx_char,
    // Timer 1
    output logic                timer1_ovf
);
    import uart_pkg::*;
    logic [2:0] div_ff;
    // Handovers that never saw ready; the bench expects none.
    int         stalls = 0;

    // Timer 1 overflows every fifth cycle, a rate unlike any internal divider.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            div_ff <= 3'h0;
        else
            div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
    assign timer1_ovf = (div_ff == 3'h4);

    // Idle line before the first character.
    initial
    begin
        rx_valid = 1'b0;
        rx_char = '0;
    end

    // bad stop, overrun
    // A blind push holds one cycle whatever rx_ready says, so the character can be lost.
    task push(input logic [7:0] d, input logic ok, input logic blind);
        int n;
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_char <= {ok, d};
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!blind && rx_ready !== 1'b1 && n < 50);
        if (!blind && rx_ready !== 1'b1)
            stalls++;
        rx_valid <= 1'b0;
        rx_char <= ~{ok, d};
    endtask : push
endmodule : rx_partner

/* bench/uart_baud_and_serial_control_tb.sv */
// Bench for the serial control block: registers, clock selection and receive path.
`timescale 1ns/1ns
module uart_baud_and_serial_control_tb;
    import uart_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [31:0]  prdata, r;
    logic         pready, pslverr, e, timer1_ovf, rx_valid, rx_ready, tx_clk_en, rx_clk_en;
    rx_char_s     rx_char;
    serial_mode_e serial_mode;
    int           mismatches = 0;
    int           checks = 0;

    always #5 pclk = ~pclk;

    uart_baud_and_serial_control uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .timer1_ovf, .rx_valid, .rx_char, .rx_ready, .tx_clk_en,
        .rx_clk_en, .serial_mode);
    rx_partner far (.pclk, .presetn, .rx_ready, .rx_valid, .rx_char, .timer1_ovf);

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task results;
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // One APB transfer; the request stands until pready is seen high at an edge.
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Set mode and clocking, let it settle, then count serial clocks over 120 cycles.
    // The window is a multiple of every source period, so the counts are exact.
    task cfg(input logic [7:0] sc, input logic [7:0] bd, input int etx, input int erx);
        logic [31:0] tx, rx;
        apb(1'b1, 12'h260, sc);
        apb(1'b1, 12'h26C, bd);
        tx = '0;
        rx = '0;
        repeat (24) @(posedge pclk);
        repeat (120)
        begin
            @(posedge pclk);
            tx = tx + tx_clk_en;
            rx = rx + rx_clk_en;
        end
        chk(tx, etx);
        chk(rx, erx);
    endtask : cfg

    // A hang anywhere ends the run as a failure.
    initial
    begin
        #200000;
        mismatches++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h26C, 8'h00);
        chk(r, 32'h0);
        chk(e, 32'h0);
        apb(1'b0, 12'h260, 8'h00);
        chk(r, 32'h0);
        apb(1'b1, 12'h26C, 8'h1F);
        apb(1'b0, 12'h26C, 8'h00);
        chk(r, 32'h1F);
        apb(1'b0, 12'h000, 8'h00);
        chk(e, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, 12'h260, 8'(m << 6));
            apb(1'b0, 12'h260, 8'h00);
            chk(r, 32'(m << 6));
            chk(serial_mode, 32'(m));
        end
        apb(1'b1, 12'h268, 8'hFF);
        cfg(8'h00, 8'h00, 10, 10);
        cfg(8'h00, 8'h01, 0, 0);
        cfg(8'h00, 8'h13, 30, 30);
        cfg(8'h40, 8'h1A, 60, 24);
        cfg(8'h40, 8'h14, 24, 10);
        apb(1'b1, 12'h260, 8'h00);
        apb(1'b1, 12'h21C, 8'h40);
        for (int i = 0; i < 8; i++)
            far.push(8'hA0 + 8'(i), i != 3, 1'b0);
        @(posedge pclk);
        chk(rx_ready, 32'h0);
        far.push(8'h55, 1'b1, 1'b1);
        // Ones under the error view neither clear the flags nor reach the mode bits.
        apb(1'b1, 12'h260, 8'hC0);
        apb(1'b0, 12'h260, 8'h00);
        chk(r, 32'hC0);
        chk(serial_mode, 32'h0);
        apb(1'b1, 12'h260, 8'h00);
        apb(1'b0, 12'h260, 8'h00);
        chk(r, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 12'h264, 8'h00);
            // Empty: valid clear over the slot that the next character will fill.
            chk(r, (i < 8) ? 32'h1A0 + 32'(i) : 32'h0A0);
        end
        chk(far.stalls, 32'h0);
        results();
    end
endmodule : uart_baud_and_serial_control_tb
